// [pkg/sram_host_pkg.sv]
package sram_host_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int DEPTH = 131072;

  // ****************************************************************
  // timing, in ns or us and in 4 ns cycles
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int POWERUP_WAIT_US = 200;
  localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 45;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESELECT_TO_RETENTION_TIME_NS = 0;
  localparam int RETENTION_RECOVERY_TIME_NS = 45;
  localparam int RETENTION_RECOVERY_CYC =
    (RETENTION_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = 1;
  localparam int CNT_W = 16;

  // ****************************************************************
  // reset values of pins
  // ****************************************************************
  localparam logic SEL_N_RESET = 1'b1;
  localparam logic SEL_H_RESET = 1'b0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic select_active_low;
    logic select_active_high;
    logic write_strobe_n;
    logic output_enable_n;
    logic [ADDR_W-1:0] address_lines;
  } sram_ctl_t;
endpackage

// [design/cycle_timer.sv]
`timescale 1ns/10ps
// ****************************************************************
// down counter: load a count, done pulses when it runs out
// ****************************************************************
module cycle_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [W-1:0] count,
  // status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_done;

  initial begin
    if (W < 2) $error("cycle_timer width too small");
  end

  // next value: a load restarts, otherwise count to zero
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (load) begin
      next_cnt = count;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign busy = (cnt != '0);
endmodule // cycle_timer

// [design/sram_host_ctrl.sv]
`timescale 1ns/10ps
// Behaviour
// - write stores data while both selects asserted and write strobe low.
// - host reads with both selects asserted, output enable low, strobe high.
// - host deselects no later than the supply drop to retention level.
// - host waits 200 us after supply is stable before any access.
// - write spans overlap of select and strobe; data held to its end.
module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_WAIT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // user request side
  input wire logic req_valid,
  input sram_host_pkg::mem_req_t req,
  output logic req_ready,
  output logic rd_valid,
  output logic [sram_host_pkg::DATA_W-1:0] rd_data,
  // retention request: deselect and report safe to drop supply
  input wire logic retain_req,
  output logic retain_safe,
  // memory pins
  output sram_host_pkg::sram_ctl_t pins,
  output logic [sram_host_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_i
);
  import sram_host_pkg::*;

  initial begin
    if (POWERUP_CYCLES < 2 || POWERUP_CYCLES >= (1 << CNT_W)) $error("bad POWERUP_CYCLES");
  end

  // ****************************************************************
  // state and registers
  // ****************************************************************
  typedef enum logic [6:0] {
    S_POWERUP = 7'b0000001,
    S_IDLE = 7'b0000010,
    S_WRITE = 7'b0000100,
    S_WEND = 7'b0001000,
    S_READ = 7'b0010000,
    S_TURN = 7'b0100000,
    S_RETAIN = 7'b1000000
  } state_t;

  state_t state, next_state;
  sram_ctl_t next_pins;
  logic [DATA_W-1:0] next_data_o, next_rd_data;
  logic next_oe, next_ready, next_rd_valid, next_retain_safe;
  logic tload;
  logic [CNT_W-1:0] tcount;
  logic tbusy, tdone;
  logic [DATA_W-1:0] din_meta, din_sync;
  logic pwr_loaded, next_pwr_loaded;

  cycle_timer #(.W(CNT_W)) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(tload),
    .count(tcount),
    .busy(tbusy),
    .done(tdone)
  );

  // read data from the pins crosses two flops before use
  always_ff @(posedge ref_clk) begin
    din_meta <= data_lines_i;
    din_sync <= din_meta;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // pins change only on state moves, so address and data never move during a strobe
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_data_o = data_lines_o;
    next_oe = data_lines_oe;
    next_ready = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_retain_safe = retain_safe;
    next_pwr_loaded = pwr_loaded;
    tload = 1'b0;
    tcount = '0;
    case (state)
      S_POWERUP: begin
        // no access before the wait runs out
        if (!pwr_loaded) begin
          tload = 1'b1;
          tcount = CNT_W'(POWERUP_CYCLES);
          next_pwr_loaded = 1'b1;
        end else if (tdone) begin
          next_state = S_IDLE;
          next_ready = 1'b1;
        end
      end
      S_IDLE: begin
        next_ready = 1'b1;
        if (retain_req) begin
          // already deselected in idle, so the supply may drop now
          next_ready = 1'b0;
          next_retain_safe = 1'b1;
          next_state = S_RETAIN;
        end else if (req_valid && req_ready) begin
          next_ready = 1'b0;
          next_pins.address_lines = req.addr;
          next_pins.select_active_low = 1'b0;
          next_pins.select_active_high = 1'b1;
          tload = 1'b1;
          if (req.write) begin
            // strobe low with both selects: data lines driven by us
            next_pins.write_strobe_n = 1'b0;
            next_pins.output_enable_n = 1'b1;
            next_data_o = req.wdata;
            next_oe = 1'b1;
            tcount = CNT_W'(WRITE_PULSE_CYC);
            next_state = S_WRITE;
          end else begin
            // read: strobe high, output enable low, our drivers off
            next_pins.write_strobe_n = 1'b1;
            next_pins.output_enable_n = 1'b0;
            next_oe = 1'b0;
            tcount = CNT_W'(READ_ACCESS_CYC + 2);
            next_state = S_READ;
          end
        end
      end
      S_WRITE: begin
        if (tdone) begin
          // strobe ends the write; address and data stay one more cycle
          next_pins.write_strobe_n = 1'b1;
          next_state = S_WEND;
        end
      end
      S_WEND: begin
        // deselect and release the data lines: standby
        next_pins.select_active_low = SEL_N_RESET;
        next_pins.select_active_high = SEL_H_RESET;
        next_oe = 1'b0;
        next_state = S_TURN;
      end
      S_READ: begin
        if (tdone) begin
          // extra two cycles cover the input synchroniser
          next_rd_data = din_sync;
          next_rd_valid = 1'b1;
          next_pins.output_enable_n = 1'b1; // memory floats the lines
          next_pins.select_active_low = SEL_N_RESET;
          next_pins.select_active_high = SEL_H_RESET;
          next_state = S_TURN;
        end
      end
      S_TURN: begin
        // one idle cycle so the memory has released the bus before we drive it
        next_ready = 1'b1;
        next_state = S_IDLE;
      end
      S_RETAIN: begin
        if (!retain_req) begin
          next_retain_safe = 1'b0;
          if (!tbusy && !tload && retain_safe) begin
            tload = 1'b1;
            tcount = CNT_W'(RETENTION_RECOVERY_CYC);
          end
        end
        if (!retain_req && tdone) begin
          next_ready = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_POWERUP;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= S_POWERUP;
      pins <= '{select_active_low: SEL_N_RESET, select_active_high: SEL_H_RESET,
                write_strobe_n: 1'b1, output_enable_n: 1'b1, address_lines: '0};
      data_lines_o <= '0;
      data_lines_oe <= 1'b0;
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      retain_safe <= 1'b0;
      pwr_loaded <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      data_lines_o <= next_data_o;
      data_lines_oe <= next_oe;
      req_ready <= next_ready;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      retain_safe <= next_retain_safe;
      pwr_loaded <= next_pwr_loaded;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  no_early_access_a: assert property (@(posedge ref_clk) disable iff (srst)
    (state == S_POWERUP) |-> pins.select_active_low && !pins.select_active_high)
    else $error("access before power-up wait");
  write_addr_stable_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!pins.write_strobe_n && $past(!pins.write_strobe_n)) |-> $stable(pins.address_lines))
    else $error("address moved during write strobe");
  write_data_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    ($rose(pins.write_strobe_n) && !pins.select_active_low) |-> data_lines_oe && $stable(data_lines_o))
    else $error("write data not held at strobe end");
  no_bus_fight_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(data_lines_oe && !pins.output_enable_n))
    else $error("host drives while memory outputs enabled");
  write_pulse_len_a: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(pins.write_strobe_n) |-> (!pins.write_strobe_n && !pins.select_active_low)[*8])
    else $error("write strobe too short");
  read_strobe_high_a: assert property (@(posedge ref_clk) disable iff (srst)
    !pins.output_enable_n |-> pins.write_strobe_n && pins.select_active_high)
    else $error("read with write strobe low or deselected");
  retain_deselected_a: assert property (@(posedge ref_clk) disable iff (srst)
    retain_safe |-> pins.select_active_low && !pins.select_active_high)
    else $error("retention signalled while selected");
  read_done_a: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(pins.output_enable_n) |-> ##[13:16] rd_valid)
    else $error("read answer late");
endmodule // sram_host_ctrl

// [verif/sram_model.sv]
`timescale 1ns/10ps
// ********
// behavioural byte memory facing the host port
// ********
module sram_model
  import sram_host_pkg::*;
(
  // pins from the host
  input sram_host_pkg::sram_ctl_t pins,
  input wire logic [sram_host_pkg::DATA_W-1:0] data_lines,
  // drive back onto the shared lines
  output logic [sram_host_pkg::DATA_W-1:0] mem_q,
  output logic mem_oe,
  output logic standby
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic sel;
  logic wr_act;
  // effective select needs both pins active; no command is needed for standby
  assign sel = !pins.select_active_low && pins.select_active_high;
  assign standby = !sel;
  assign wr_act = sel && !pins.write_strobe_n;
  // drivers on only for a selected read, so a write never fights the host
  assign mem_oe = sel && !pins.output_enable_n && pins.write_strobe_n;
  assign mem_q = mem[pins.address_lines];
  // byte lands at the edge ending the overlap: data need only be valid there
  always @(negedge wr_act) begin
    mem[pins.address_lines] <= data_lines;
  end
endmodule // sram_model

// [verif/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import sram_host_pkg::*;
  // ********
  // clock, reset and wiring
  // ********
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic req_valid = 1'h0;
  mem_req_t req = '0;
  logic retain_req = 1'h0;
  logic req_ready, rd_valid, retain_safe, dl_oe, mem_oe, standby, sel, wr_ov;
  logic prev_wr = 1'h0;
  logic prev_rdv = 1'h0;
  logic [ADDR_W-1:0] prev_addr;
  logic [DATA_W-1:0] rd_data, dl_o, mem_q, prev_data;
  logic [DATA_W-1:0] last_bus = 8'h00;
  wire [DATA_W-1:0] bus;
  sram_ctl_t pins;
  int mismatches = 0;
  int checked = 0;
  // clock at 4 ns
  always #2 ref_clk = ~ref_clk;
  // a released line shows a byte that moves every cycle, never a stale one
  assign bus = dl_oe ? dl_o : (mem_oe ? mem_q : ~last_bus);
  assign sel = !pins.select_active_low && pins.select_active_high;
  assign wr_ov = sel && !pins.write_strobe_n;
  always @(posedge ref_clk) begin
    last_bus <= bus;
  end
  sram_host_ctrl #(.POWERUP_CYCLES(20)) i_sram_host_ctrl (.ref_clk(ref_clk), .srst(srst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .retain_req(retain_req), .retain_safe(retain_safe), .pins(pins),
    .data_lines_o(dl_o), .data_lines_oe(dl_oe), .data_lines_i(bus));
  sram_model i_sram_model (.pins(pins), .data_lines(bus), .mem_q(mem_q), .mem_oe(mem_oe),
    .standby(standby));
  // ********
  // compare, verdict
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    results();
  endtask
  // pin watch: stable overlap, no read while strobing, no contention
  always @(posedge ref_clk) begin
    if (wr_ov && prev_wr) begin
      check(pins.address_lines, prev_addr);
      check(dl_o, prev_data);
    end
    if (wr_ov) check(dl_oe, 1'h1);
    if (sel && !pins.output_enable_n) check(pins.write_strobe_n, 1'h1);
    if (retain_safe) check(sel, 1'h0);
    if (dl_oe) check(mem_oe, 1'h0);
    // read answer is a single-cycle pulse, a longer one would be taken twice
    if (prev_rdv) check(rd_valid, 1'h0);
    prev_rdv <= rd_valid;
    prev_wr <= wr_ov;
    prev_addr <= pins.address_lines;
    prev_data <= dl_o;
  end
  // ********
  // transfers and scenarios
  // ********
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    int n;
    logic ok;
    ok = 1'h0;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req <= '{write: w, addr: a, wdata: d};
    for (n = 0; n < 200 && !ok; n++) begin
      #1;
      ok = (req_ready === 1'h1);
      @(posedge ref_clk);
    end
    if (!ok) hang();
    req_valid <= 1'h0;
    q = 8'h00;
    if (!w) begin
      for (n = 1; n <= 100; n++) begin
        @(posedge ref_clk);
        #1;
        if (rd_valid === 1'h1) break;
      end
      if (n > 100) hang();
      check(n, 15);
      q = rd_data;
    end
  endtask
  task automatic wait_ready(output int n);
    for (n = 0; n < 500; n++) begin
      @(posedge ref_clk);
      #1;
      if (req_ready === 1'h1) break;
      check(sel, 1'h0);
    end
    if (n >= 500) hang();
  endtask
  task automatic t_powerup();
    int n;
    repeat (2) @(posedge ref_clk);
    #1;
    check({pins.select_active_low, pins.select_active_high}, 2'h2);
    check({pins.write_strobe_n, pins.output_enable_n, dl_oe}, 3'h6);
    @(posedge ref_clk);
    srst <= 1'h0;
    wait_ready(n);
    check(n >= 20, 1'h1);
  endtask
  task automatic t_write_read();
    logic [ADDR_W-1:0] a [4] = '{17'h00000, 17'h1ffff, 17'h0a5a5, 17'h10000};
    logic [DATA_W-1:0] d [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
    logic [DATA_W-1:0] r;
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, a[i], d[i], r);
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'h0, a[i], 8'h00, r);
      check(r, d[i]);
    end
  endtask
  task automatic t_overwrite();
    logic [DATA_W-1:0] r;
    xfer(1'h1, 17'h00003, 8'h11, r);
    xfer(1'h1, 17'h00003, 8'h22, r);
    xfer(1'h0, 17'h00003, 8'h00, r);
    check(r, 8'h22);
  endtask
  task automatic t_retain();
    int n;
    logic [DATA_W-1:0] r;
    @(posedge ref_clk);
    retain_req <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      #1;
      if (retain_safe === 1'h1) break;
    end
    if (n >= 50) hang();
    repeat (5) @(posedge ref_clk);
    #1;
    check(req_ready, 1'h0);
    check(standby, 1'h1);
    @(posedge ref_clk);
    retain_req <= 1'h0;
    wait_ready(n);
    check(n >= 12, 1'h1);
    check(retain_safe, 1'h0);
    xfer(1'h0, 17'h1ffff, 8'h00, r);
    check(r, 8'ha5);
  endtask
  // main sequence
  initial begin
    t_powerup();
    t_write_read();
    t_overwrite();
    t_retain();
    results();
  end
endmodule // tb_top
